// ---- rtl/cbd_core.sv ----
// Bit-test/branch/arithmetic subset of an 8-bit core with an AXI4-Lite register slave
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
module cbd_core
    import cbd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Memory port
    output logic [15:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    // Request sources for the request byte
    input wire logic [7:0] irq_in,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic [3:0] {
        S_IDLE = 4'b0000, S_FETCH = 4'b0001, S_OPR1 = 4'b0010, S_OPR2 = 4'b0011,
        S_RDM = 4'b0100, S_RDX = 4'b0101, S_WRM = 4'b0110, S_PSHH = 4'b0111,
        S_PSHL = 4'b1000, S_PAD = 4'b1001
    } cbd_st_type;
    typedef enum logic [2:0] {
        K_ILL = 3'b000, K_IMP = 3'b001, K_IMM = 3'b010, K_ZP = 3'b011,
        K_REL = 3'b100, K_BBA = 3'b101, K_BBZ = 3'b110, K_CALL = 3'b111
    } cbd_kind_type;
    typedef struct packed {
        cbd_st_type st;
        logic [15:0] pc;
        logic [7:0] a, x, s, p, op, o1, m;
        logic [2:0] cnt, tot;
        logic [15:0] addr;
        logic rd, wr;
        logic [7:0] wd, irq, snap, prev;
        logic run, ill;
        logic [7:0] tload;
        logic [8:0] tcnt;
        logic [7:0] tevt;
        logic awr, wrr, aw_got, w_got;
        logic [7:0] awa;
        logic [31:0] wdat;
        logic [3:0] wstb;
        logic bv;
        logic [1:0] br;
        logic arr, rv;
        logic [1:0] rr;
        logic [31:0] rdat;
    } cbd_state_type;

    cbd_state_type r, n;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic cbd_kind_type kind(input logic [7:0] op);
        if (op[3:0] == BB_ACC_LOW && !op[5 - 2 +: 1]) return K_BBA;
        if (op[3:0] == BB_ZP_LOW && !op[3]) return K_BBZ;
        unique case (op)
            OP_SHL_A, OP_CLR_T, OP_CLR_C: return K_IMP;
            OP_ADC_IMM, OP_AND_IMM: return K_IMM;
            OP_ADC_ZP, OP_AND_ZP, OP_TEST_ZP, OP_SHL_ZP: return K_ZP;
            OP_BR_CC, OP_BR_CS, OP_BR_Z, OP_BR_NZ, OP_BR_N, OP_BR_P, OP_JUMP: return K_REL;
            OP_CALL_SP: return K_CALL;
            default: return K_ILL;
        endcase
    endfunction

    function automatic logic [2:0] cycles(input logic [7:0] op, input logic t);
        logic [2:0] c;
        c = CYC_TWO;
        unique case (kind(op))
            K_BBA: c = CYC_BB_ACC;
            K_BBZ: c = CYC_BB_ZP;
            K_CALL: c = CYC_CALL;
            K_ZP: c = (op == OP_SHL_ZP) ? CYC_SHL_ZP : CYC_ZP;
            K_REL: c = (op == OP_JUMP) ? CYC_JUMP : CYC_TWO;
            default: c = CYC_TWO;
        endcase
        if (t && (op == OP_ADC_IMM || op == OP_ADC_ZP || op == OP_AND_IMM || op == OP_AND_ZP))
            c = c + CYC_T_EXTRA;
        return c;
    endfunction

    // Returns {new flags, result}
    function automatic logic [15:0] alu(input logic is_and, input logic [7:0] x, y, p);
        logic [8:0] sum;
        logic [7:0] res, np;
        sum = {1'b0, x} + {1'b0, y} + {8'h00, p[FL_C]};
        np = p;
        if (is_and) begin
            res = x & y;
        end else begin
            res = sum[7:0];
            np[FL_C] = sum[8];
            np[FL_V] = (x[7] == y[7]) && (res[7] != x[7]);
        end
        np[FL_N] = res[7];
        np[FL_Z] = (res == 8'h00);
        return {np, res};
    endfunction

    function automatic logic take(input logic [7:0] op, input logic [7:0] p);
        unique case (op)
            OP_BR_CC: return !p[FL_C];
            OP_BR_CS: return p[FL_C];
            OP_BR_Z: return p[FL_Z];
            OP_BR_NZ: return !p[FL_Z];
            OP_BR_N: return p[FL_N];
            OP_BR_P: return !p[FL_N];
            default: return 1'b1;
        endcase
    endfunction

    function automatic logic [15:0] rel(input logic [15:0] pc, input logic [7:0] off);
        return pc + {{8{off[7]}}, off};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, wd, input logic [3:0] st);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) m[8*i +: 8] = wd[8*i +: 8];
        end
        return m;
    endfunction

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        logic [7:0] v;
        logic [15:0] f;
        logic [31:0] w;
        logic done, bit_v;
        n = r;
        v = (r.addr == IRQ_ADDR) ? r.irq : mem_rdata;
        f = 16'h0000;
        w = 32'h0000_0000;
        done = 1'b0;
        bit_v = 1'b0;
        n.rd = 1'b0;
        n.wr = 1'b0;
        n.cnt = r.cnt + 3'd1;
        n.irq = r.irq | irq_in;
        // Period of load+2: reload with load+1 and count down through zero
        if (r.tcnt == 9'd0) begin
            n.tcnt = {1'b0, r.tload} + TMR_EXTRA;
            n.tevt = r.tevt + 8'd1;
        end else begin
            n.tcnt = r.tcnt - 9'd1;
        end

        unique case (r.st)
            S_IDLE: begin
                if (r.run) begin
                    n.st = S_FETCH;
                    n.addr = r.pc;
                    n.rd = 1'b1;
                    n.cnt = 3'd0;
                end
            end
            S_FETCH: begin
                n.op = v;
                n.pc = r.pc + 16'd1;
                n.tot = cycles(v, r.p[FL_T]);
                // Two-deep history keeps bit branches on the request byte one instruction behind
                n.snap = r.irq;
                n.prev = r.snap;
                if (kind(v) == K_ILL) begin
                    n.st = S_IDLE;
                    n.run = 1'b0;
                    n.ill = 1'b1;
                end else begin
                    n.st = S_OPR1;
                    n.addr = r.pc + 16'd1;
                    n.rd = 1'b1;
                end
            end
            S_OPR1: begin
                n.o1 = v;
                unique case (kind(r.op))
                    K_IMP: begin
                        done = 1'b1;
                        if (r.op == OP_SHL_A) begin
                            n.a = {r.a[6:0], 1'b0};
                            n.p[FL_C] = r.a[7];
                            n.p[FL_N] = r.a[6];
                            n.p[FL_Z] = (r.a[6:0] == 7'h00);
                        end else if (r.op == OP_CLR_T) begin
                            n.p[FL_T] = 1'b0;
                        end else begin
                            n.p[FL_C] = 1'b0;
                        end
                    end
                    K_IMM: begin
                        n.pc = r.pc + 16'd1;
                        if (r.p[FL_T]) begin
                            n.m = v;
                            n.addr = {8'h00, r.x};
                            n.rd = 1'b1;
                            n.st = S_RDX;
                        end else begin
                            f = alu(r.op == OP_AND_IMM, r.a, v, r.p);
                            {n.p, n.a} = f;
                            done = 1'b1;
                        end
                    end
                    K_ZP: begin
                        n.pc = r.pc + 16'd1;
                        n.addr = {8'h00, v};
                        n.rd = 1'b1;
                        n.st = S_RDM;
                    end
                    K_REL: begin
                        n.pc = take(r.op, r.p) ? rel(r.pc + 16'd1, v) : r.pc + 16'd1;
                        done = 1'b1;
                    end
                    K_BBA: begin
                        bit_v = r.a[r.op[7:5]];
                        n.pc = (bit_v ^ r.op[4]) ? rel(r.pc + 16'd1, v) : r.pc + 16'd1;
                        done = 1'b1;
                    end
                    K_BBZ: begin
                        n.pc = r.pc + 16'd1;
                        n.addr = r.pc + 16'd1;
                        n.rd = 1'b1;
                        n.st = S_OPR2;
                    end
                    default: begin
                        // Special-page call: push high then low of the next address
                        n.pc = r.pc + 16'd1;
                        n.addr = {STACK_PAGE, r.s};
                        n.wd = n.pc[15:8];
                        n.wr = 1'b1;
                        n.st = S_PSHH;
                    end
                endcase
            end
            S_OPR2: begin
                n.m = v;
                n.pc = r.pc + 16'd1;
                n.addr = {8'h00, r.o1};
                n.rd = 1'b1;
                n.st = S_RDM;
            end
            S_RDM: begin
                unique case (kind(r.op))
                    K_BBZ: begin
                        bit_v = (r.addr == IRQ_ADDR) ? r.prev[r.op[7:5]] : v[r.op[7:5]];
                        n.pc = (bit_v ^ r.op[4]) ? rel(r.pc, r.m) : r.pc;
                        done = 1'b1;
                    end
                    default: begin
                        if (r.op == OP_TEST_ZP) begin
                            n.p[FL_Z] = ((r.a & v) == 8'h00);
                            n.p[FL_N] = v[7];
                            n.p[FL_V] = v[6];
                            done = 1'b1;
                        end else if (r.op == OP_SHL_ZP) begin
                            n.wd = {v[6:0], 1'b0};
                            n.p[FL_C] = v[7];
                            n.p[FL_N] = v[6];
                            n.p[FL_Z] = (v[6:0] == 7'h00);
                            n.wr = 1'b1;
                            n.st = S_WRM;
                        end else if (r.p[FL_T]) begin
                            n.m = v;
                            n.addr = {8'h00, r.x};
                            n.rd = 1'b1;
                            n.st = S_RDX;
                        end else begin
                            f = alu(r.op == OP_AND_ZP, r.a, v, r.p);
                            {n.p, n.a} = f;
                            done = 1'b1;
                        end
                    end
                endcase
            end
            S_RDX: begin
                f = alu(r.op == OP_AND_IMM || r.op == OP_AND_ZP, v, r.m, r.p);
                n.p = f[15:8];
                n.wd = f[7:0];
                n.wr = 1'b1;
                n.st = S_WRM;
            end
            S_WRM: begin
                if (r.addr == IRQ_ADDR) n.irq = r.wd | irq_in;
                done = 1'b1;
            end
            S_PSHH: begin
                n.s = r.s - 8'd1;
                n.addr = {STACK_PAGE, r.s - 8'd1};
                n.wd = r.pc[7:0];
                n.wr = 1'b1;
                n.st = S_PSHL;
            end
            S_PSHL: begin
                n.s = r.s - 8'd1;
                n.pc = {SPECIAL_PAGE, r.o1};
                done = 1'b1;
            end
            default: done = 1'b1;
        endcase

        // Hold the documented cycle count before the next fetch
        if (done) begin
            if (r.cnt != r.tot - 3'd1) begin
                n.st = S_PAD;
            end else if (r.run) begin
                n.st = S_FETCH;
                n.addr = n.pc;
                n.rd = 1'b1;
                n.cnt = 3'd0;
            end else begin
                n.st = S_IDLE;
            end
        end

        // ----------------------------------------
        // AXI4-Lite write channel
        // ----------------------------------------
        if (r.awr && s_axi_awvalid) begin
            n.aw_got = 1'b1;
            n.awa = s_axi_awaddr;
        end
        if (r.wrr && s_axi_wvalid) begin
            n.w_got = 1'b1;
            n.wdat = s_axi_wdata;
            n.wstb = s_axi_wstrb;
        end
        if (r.bv && s_axi_bready) n.bv = 1'b0;
        if (r.aw_got && r.w_got && !r.bv) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bv = 1'b1;
            n.br = RESP_OKAY;
            unique case (r.awa)
                REG_CTRL: begin
                    w = merge({30'h0, r.ill, r.run}, r.wdat, r.wstb);
                    // A stop raised in this very cycle wins over the clear
                    if (w[CTRL_RUN] && !r.run && !(n.ill && !r.ill)) n.ill = 1'b0;
                    n.run = w[CTRL_RUN];
                end
                REG_PC: begin
                    w = merge({16'h0, r.pc}, r.wdat, r.wstb);
                    n.pc = w[15:0];
                end
                REG_CORE: begin
                    w = merge({r.p, r.s, r.x, r.a}, r.wdat, r.wstb);
                    {n.p, n.s, n.x, n.a} = w;
                end
                REG_TLOAD: begin
                    w = merge({24'h0, r.tload}, r.wdat, r.wstb);
                    n.tload = w[7:0];
                end
                REG_TSTAT, REG_IRQ: ;
                default: n.br = RESP_SLVERR;
            endcase
        end
        n.awr = !n.aw_got && !n.bv;
        n.wrr = !n.w_got && !n.bv;

        // ----------------------------------------
        // AXI4-Lite read channel
        // ----------------------------------------
        if (r.rv && s_axi_rready) begin
            n.rv = 1'b0;
            n.arr = 1'b1;
        end
        if (r.arr && s_axi_arvalid) begin
            n.arr = 1'b0;
            n.rv = 1'b1;
            n.rr = RESP_OKAY;
            unique case (s_axi_araddr)
                REG_CTRL: n.rdat = {30'h0, r.ill, r.run};
                REG_PC: n.rdat = {16'h0, r.pc};
                REG_CORE: n.rdat = {r.p, r.s, r.x, r.a};
                REG_TLOAD: n.rdat = {24'h0, r.tload};
                REG_TSTAT: n.rdat = {8'h0, r.tevt, 7'h0, r.tcnt};
                REG_IRQ: n.rdat = {24'h0, r.irq};
                default: begin
                    n.rdat = 32'h0000_0000;
                    n.rr = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
            r.s <= SP_RST;
            r.tload <= TLOAD_RST;
            r.awr <= 1'b1;
            r.wrr <= 1'b1;
            r.arr <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign mem_addr = r.addr;
    assign mem_rd = r.rd;
    assign mem_wr = r.wr;
    assign mem_wdata = r.wd;
    assign s_axi_awready = r.awr;
    assign s_axi_wready = r.wrr;
    assign s_axi_bvalid = r.bv;
    assign s_axi_bresp = r.br;
    assign s_axi_arready = r.arr;
    assign s_axi_rvalid = r.rv;
    assign s_axi_rdata = r.rdat;
    assign s_axi_rresp = r.rr;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Period length is judged against the load value taken at the reload, so a mid-period load is no false alarm
    logic [8:0] gap_q;
    logic [7:0] per_q;
    always_ff @(posedge clk) begin
        if (rst || r.tcnt == 9'd0) begin
            gap_q <= 9'd0;
            per_q <= r.tload;
        end else begin
            gap_q <= gap_q + 9'd1;
        end
    end

    sequence s_call_push;
        r.st == S_PSHH && mem_wr && mem_addr[15:8] == STACK_PAGE ##1 r.st == S_PSHL && mem_wr;
    endsequence
    property p_call;
        r.st == S_OPR1 && r.op == OP_CALL_SP |=> s_call_push ##2 (r.st == S_FETCH && r.pc[15:8] == SPECIAL_PAGE);
    endproperty
    a_call: assert property (p_call) else $error("special-page call wrong");
    property p_bba_len;
        r.st == S_OPR1 && r.op[3:0] == BB_ACC_LOW && !r.op[3] |-> ##3 r.st == S_FETCH;
    endproperty
    a_bba_len: assert property (p_bba_len) else $error("accumulator bit branch length");
    property p_bbz_len;
        r.st == S_OPR1 && r.op[3:0] == BB_ZP_LOW && !r.op[3] |-> ##1 r.st == S_OPR2 ##1 r.st == S_RDM ##2 r.st == S_FETCH;
    endproperty
    a_bbz_len: assert property (p_bbz_len) else $error("zero-page bit branch length");
    property p_cond_br;
        r.st == S_OPR1 && kind(r.op) == K_REL && r.op != OP_JUMP |=> r.st == S_FETCH && $stable(r.p);
    endproperty
    a_cond_br: assert property (p_cond_br) else $error("conditional branch timing or flags");
    property p_jump;
        r.st == S_OPR1 && r.op == OP_JUMP |=> r.pc == rel($past(r.pc) + 16'd1, r.o1) ##2 r.st == S_FETCH;
    endproperty
    a_jump: assert property (p_jump) else $error("jump target or length");
    property p_shl_a;
        r.st == S_OPR1 && r.op == OP_SHL_A |=> r.a == {$past(r.a[6:0]), 1'b0} && r.p[FL_C] == $past(r.a[7]);
    endproperty
    a_shl_a: assert property (p_shl_a) else $error("shift-left result");
    property p_test;
        r.st == S_RDM && r.op == OP_TEST_ZP |=> r.p[7:6] == $past(mem_rdata[7:6]) && $stable(r.a) && !mem_wr;
    endproperty
    a_test: assert property (p_test) else $error("mask test flags");
    property p_xdest;
        r.st == S_RDX |=> mem_wr && mem_addr == {8'h00, r.x};
    endproperty
    a_xdest: assert property (p_xdest) else $error("indexed destination address");
    property p_timer;
        r.tcnt == 9'd0 && $past(r.tcnt) == 9'd1 |-> gap_q == {1'b0, per_q} + 9'd1;
    endproperty
    a_timer: assert property (p_timer) else $error("timer period not load plus two");
endmodule // cbd_core

// ---- rtl/cbd_pkg.sv ----
// Constants for the bit-and-branch decode core and its register slave
package cbd_pkg;
    // AXI4-Lite register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PC = 8'h04;
    localparam logic [7:0] REG_CORE = 8'h08;
    localparam logic [7:0] REG_TLOAD = 8'h0c;
    localparam logic [7:0] REG_TSTAT = 8'h10;
    localparam logic [7:0] REG_IRQ = 8'h14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Field positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_ILL = 1;
    localparam int FL_N = 7;
    localparam int FL_V = 6;
    localparam int FL_T = 5;
    localparam int FL_Z = 1;
    localparam int FL_C = 0;
    // Reset values
    localparam logic [7:0] SP_RST = 8'hff;
    localparam logic [7:0] TLOAD_RST = 8'h01;
    // Fixed pages
    localparam logic [7:0] SPECIAL_PAGE = 8'h1f;
    localparam logic [7:0] STACK_PAGE = 8'h01;
    localparam logic [15:0] IRQ_ADDR = 16'h00fe;
    // Opcodes
    localparam logic [7:0] OP_CALL_SP = 8'h22;
    localparam logic [7:0] OP_ADC_IMM = 8'h69;
    localparam logic [7:0] OP_ADC_ZP = 8'h65;
    localparam logic [7:0] OP_AND_IMM = 8'h29;
    localparam logic [7:0] OP_AND_ZP = 8'h25;
    localparam logic [7:0] OP_SHL_A = 8'h0a;
    localparam logic [7:0] OP_SHL_ZP = 8'h06;
    localparam logic [7:0] OP_TEST_ZP = 8'h24;
    localparam logic [7:0] OP_CLR_T = 8'h12;
    localparam logic [7:0] OP_CLR_C = 8'h18;
    localparam logic [7:0] OP_BR_CC = 8'h90;
    localparam logic [7:0] OP_BR_CS = 8'hb0;
    localparam logic [7:0] OP_BR_Z = 8'hf0;
    localparam logic [7:0] OP_BR_NZ = 8'hd0;
    localparam logic [7:0] OP_BR_N = 8'h30;
    localparam logic [7:0] OP_BR_P = 8'h10;
    localparam logic [7:0] OP_JUMP = 8'h80;
    localparam logic [3:0] BB_ACC_LOW = 4'h3;
    localparam logic [3:0] BB_ZP_LOW = 4'h7;
    // Cycle counts per instruction
    localparam logic [2:0] CYC_TWO = 3'd2;
    localparam logic [2:0] CYC_ZP = 3'd3;
    localparam logic [2:0] CYC_JUMP = 3'd4;
    localparam logic [2:0] CYC_BB_ACC = 3'd4;
    localparam logic [2:0] CYC_BB_ZP = 3'd5;
    localparam logic [2:0] CYC_SHL_ZP = 3'd5;
    localparam logic [2:0] CYC_CALL = 3'd5;
    localparam logic [2:0] CYC_T_EXTRA = 3'd2;
    // Timer divides by load plus two
    localparam logic [8:0] TMR_EXTRA = 9'd1;
endpackage

// ---- test/cbd_mem.sv ----
// Asynchronous program and data memory facing the core
`timescale 1ns/1ns
module cbd_mem (
    // Core side
    input wire logic clk,
    input wire logic [15:0] addr,
    input wire logic wr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] m [0:65535];
    // Erased cells read ff, an opcode the core refuses, so a program that runs past its own bytes stops there
    initial for (int i = 0; i < 65536; i++) m[i] = 8'hff;
    assign rdata = m[addr];
    always @(posedge clk) if (wr) m[addr] <= wdata;
endmodule // cbd_mem

// ---- test/testbench.sv ----
// Self-checking bench for the bit-and-branch decode core
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; $display("Error %s expected %h seen %h", n, e, g); end end
module testbench;
    import cbd_pkg::*;
    logic clk = 0, rst = 1, aw_v = 0, w_v = 0, ar_v = 0;
    logic [7:0] aw_a = 0, ar_a = 0;
    logic [31:0] w_d = 0, rv, cv, r_d;
    logic [15:0] ma;
    logic [7:0] wd, rdat;
    logic [7:0] irq_s = 8'h00;
    logic we, mr, aw_r, w_r, b_v, ar_r, r_v;
    logic [1:0] b_s, r_s, rs, bs_q;
    int bad_count = 0, compares = 0;
    // {a, p, three program bytes, expected a, expected p}
    logic [55:0] rows [19] = '{56'h7f01_6900ff_80c0, 56'hf300_290fff_0300, 56'h8100_0affff_0201,
        56'h3f00_2410ff_3fc2, 56'h0100_90010a_0100, 56'h0100_b0010a_0200, 56'h0102_f0010a_0102,
        56'h0102_d0010a_0200, 56'h0180_30010a_0180, 56'h0180_10010a_0200, 56'h0100_80010a_0100,
        56'h8000_e3010a_8000, 56'h0100_13010a_0200, 56'h0100_33010a_0100, 56'h0100_070afe_0200,
        56'h0100_170afe_0100, 56'h0101_18ffff_0100, 56'h0100_6510ff_c180, 56'hf000_2510ff_c080};
    always #5 clk = ~clk;
    cbd_core dut_u (.clk(clk), .rst(rst), .mem_addr(ma), .mem_rd(mr), .mem_wr(we), .mem_wdata(wd),
        .mem_rdata(rdat), .irq_in(irq_s), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
        .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_s),
        .s_axi_bvalid(b_v), .s_axi_bready(1'b1), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
        .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_s), .s_axi_rvalid(r_v), .s_axi_rready(1'b1));
    cbd_mem mem_u (.clk(clk), .addr(ma), .wr(we), .wdata(wd), .rdata(rdat));
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pa = 1'b1, pw = 1'b1;
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        while (pa || pw) begin
            @(posedge clk);
            if (pa && aw_r === 1'b1) begin
                aw_v <= 1'b0;
                pa = 1'b0;
            end
            if (pw && w_r === 1'b1) begin
                w_v <= 1'b0;
                pw = 1'b0;
            end
        end
        do @(posedge clk); while (b_v !== 1'b1);
        bs_q = b_s;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
        ar_a <= a;
        ar_v <= 1'b1;
        do @(posedge clk); while (ar_r !== 1'b1);
        ar_v <= 1'b0;
        do @(posedge clk); while (r_v !== 1'b1);
        d = r_d;
        s = r_s;
    endtask
    // Loads three bytes at 0200, starts the core there and waits for the stop
    task automatic run(input logic [31:0] core, input logic [23:0] prog);
        {mem_u.m[16'h0200], mem_u.m[16'h0201], mem_u.m[16'h0202]} = prog;
        wr(REG_PC, 32'h0000_0200);
        wr(REG_CORE, core);
        wr(REG_CTRL, 32'h0000_0001);
        rv = 32'h1;
        for (int i = 0; i < 50 && rv[0] !== 1'b0; i++) rd(REG_CTRL, rv, rs);
        `CHK("stop", 1'b0, rv[0])
        rd(REG_CORE, cv, rs);
        `CHK("rd_idle", 1'b0, mr)
    endtask
    task automatic end_of_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        mem_u.m[16'h0010] = 8'hc0;
        mem_u.m[16'h0030] = 8'h10;
        foreach (rows[k]) begin
            run({rows[k][47:40], 8'hff, 8'h00, rows[k][55:48]}, rows[k][39:16]);
            `CHK("acc", rows[k][15:8], cv[7:0])
            `CHK("flags", rows[k][7:0], cv[31:24])
        end
        run(32'h00ff_0000, 24'h22e0ff);
        `CHK("stack", 8'hfd, cv[23:16])
        `CHK("ret", 16'h0202, {mem_u.m[16'h01ff], mem_u.m[16'h01fe]})
        run(32'h20ff_3005, 24'h6903ff);
        `CHK("acc_keep", 8'h05, cv[7:0])
        `CHK("mx_add", 8'h13, mem_u.m[16'h0030])
        run(32'h20ff_3005, 24'h2931ff);
        `CHK("mx_and", 8'h11, mem_u.m[16'h0030])
        run(32'h20ff_3005, 24'h126901);
        `CHK("acc_clt", 8'h06, cv[7:0])
        // Pin sets a request bit, then the core shifts it; the bit branch right after must see the old byte
        irq_s <= 8'h01;
        @(posedge clk);
        irq_s <= 8'h00;
        {mem_u.m[16'h0203], mem_u.m[16'h0204], mem_u.m[16'h0205]} = 24'hfe010a;
        run(32'h00ff_0001, 24'h06fe27);
        `CHK("acc_old_req", 8'h02, cv[7:0])
        rd(REG_IRQ, rv, rs);
        `CHK("req_byte", 8'h02, rv[7:0])
        wr(REG_TLOAD, 32'h0000_0003);
        `CHK("bresp", RESP_OKAY, bs_q)
        repeat (20) @(posedge clk);
        rd(REG_TSTAT, rv, rs);
        `CHK("tcnt_range", 1'b1, rv[8:0] <= 9'd4)
        wr(8'h40, 32'h0000_0000);
        `CHK("bresp_err", RESP_SLVERR, bs_q)
        rd(8'h40, rv, rs);
        `CHK("resp", RESP_SLVERR, rs)
        // Reset with the core stopped brings every register back
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(REG_CORE, cv, rs);
        `CHK("rst_core", 32'h00ff_0000, cv)
        rd(REG_TLOAD, rv, rs);
        `CHK("rst_tload", 32'h0000_0001, rv)
        end_of_test();
    end
endmodule // testbench
